// [core/dram_ctrl_end.sv]
// Controller end: issues row, precharge, refresh and mode commands.
// Assumes the user holds a request until done or reject pulses.
`timescale 1ns/1ps
module dram_ctrl_end #(
  parameter int REFI4_CYC = dram_pkg::REFI4_CYC
)(
  input  logic                i_sys_clk,
  input  logic                i_reset,
  input  logic                i_clk_en,
  dram_cmd_if.ctrl            link,
  input  logic                i_req_valid,
  input  dram_pkg::req_t      i_req_kind,
  input  logic [3:0]          i_req_bank,
  input  logic [17:0]         i_req_row,
  input  logic                i_req_ap,
  input  logic [2:0]          i_req_rate,
  output logic                o_req_done,
  output logic                o_req_reject,
  output logic                o_ref_urgent,
  output logic signed [7:0]   o_ref_debt,
  output logic [15:0]         o_bank_open,
  output logic [2:0]          o_rate_mode
);
  localparam int TW = dram_pkg::TIMER_W;
  localparam logic [TW-1:0] AGE_MAX = 8'hFF;

  logic [15:0]          bank_zero;
  logic [15:0]          bank_load;
  logic [TW-1:0]        bank_value;
  logic                 ref_zero;
  logic [TW-1:0]        act_age;
  logic [1:0]           last_bg;
  logic [TW-1:0]        win_age [4];
  logic [1:0]           win_ptr;
  logic [9:0]           tick_cnt;
  logic                 tick;
  logic                 ok;
  logic                 bad;
  logic                 take;
  logic                 issue;
  logic                 is_ref;
  logic                 act_ok;
  logic                 all_idle;
  logic                 pull_ok;
  logic                 hit_open;
  dram_pkg::rate_t      rate_now;
  logic [3:0]           units;
  logic signed [7:0]    next_debt;
  logic [17:0]          next_addr;

  //////////////////////////////////////////////////////////////////////
  // Per-bank ready timers, restarted by every precharge
  for (genvar b = 0; b < dram_pkg::NB; b++)
  begin : g_bank
    dram_down_counter #(.W(TW)) u_timer (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_load    (bank_load[b]),
      .i_value   (bank_value),
      .o_zero    (bank_zero[b])
    );
  end

  // Refresh cycle time: the link carries only deselect meanwhile
  dram_down_counter #(.W(TW)) u_ref_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .i_load    (issue && is_ref),
    .i_value   (dram_pkg::refresh_cycles(rate_now)),
    .o_zero    (ref_zero)
  );

  //////////////////////////////////////////////////////////////////////
  // Legality of the pending request
  assign rate_now = dram_pkg::ref_rate(o_rate_mode, i_req_rate[0]);
  assign units    = dram_pkg::refresh_units(rate_now);
  assign hit_open = o_bank_open[i_req_bank];
  assign is_ref   = (i_req_kind == dram_pkg::REQ_REF);
  assign act_ok   = bank_zero[i_req_bank] &&
                    act_age >= ((last_bg == i_req_bank[3:2]) ?
                    TW'(dram_pkg::RRDL_CYC) :
                    TW'(dram_pkg::RRDS_CYC)) &&
                    win_age[win_ptr] >= TW'(dram_pkg::WIN_CYC);
  assign all_idle = ~|o_bank_open && &bank_zero;
  assign pull_ok  = (o_ref_debt - $signed({4'h0, units})) >=
                    -dram_pkg::DEBT_LIM;

  // Urgent debt holds off activate, read and write; precharge, refresh and mode pass
  always_comb
  begin
    ok  = 1'b0;
    bad = 1'b0;
    unique case (i_req_kind)
      dram_pkg::REQ_ACT:
      begin
        bad = hit_open;
        ok  = act_ok && !o_ref_urgent;
      end
      dram_pkg::REQ_RD, dram_pkg::REQ_WR:
      begin
        bad = !hit_open;
        ok  = !o_ref_urgent;
      end
      dram_pkg::REQ_PRE, dram_pkg::REQ_PREA: ok = 1'b1;
      dram_pkg::REQ_REF: ok = all_idle && pull_ok;
      dram_pkg::REQ_MODE:
      begin
        bad = !dram_pkg::mode_legal(i_req_rate);
        ok  = all_idle;
      end
      default: bad = 1'b1;
    endcase
  end

  // One idle cycle after each answer keeps a held request single
  assign take  = i_req_valid && ref_zero && !o_req_done &&
                 !o_req_reject;
  assign issue = take && ok && !bad;

  //////////////////////////////////////////////////////////////////////
  // Address and strobe pattern of the command
  always_comb
  begin
    next_addr = '0;
    unique case (i_req_kind)
      dram_pkg::REQ_ACT: next_addr = i_req_row;
      dram_pkg::REQ_RD, dram_pkg::REQ_WR:
      begin
        next_addr[dram_pkg::RAS_BIT] = 1'b1;
        next_addr[dram_pkg::WE_BIT]  = (i_req_kind == dram_pkg::REQ_RD);
        next_addr[dram_pkg::AP_BIT]  = i_req_ap;
      end
      dram_pkg::REQ_PRE, dram_pkg::REQ_PREA:
      begin
        next_addr[dram_pkg::CAS_BIT] = 1'b1;
        next_addr[dram_pkg::AP_BIT]  = (i_req_kind == dram_pkg::REQ_PREA);
      end
      dram_pkg::REQ_REF: next_addr[dram_pkg::WE_BIT] = 1'b1;
      dram_pkg::REQ_MODE:
        next_addr[dram_pkg::RATE_LSB +: 3] = i_req_rate;
      default: next_addr = '0;
    endcase
  end

  // Link pins, deselect whenever nothing is issued
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      link.cs_n  <= 1'b1;
      link.act_n <= 1'b1;
      link.bg    <= 2'h0;
      link.ba    <= 2'h0;
      link.addr  <= '0;
    end
    else if (i_clk_en)
    begin
      link.cs_n  <= !issue;
      link.act_n <= !(issue && i_req_kind == dram_pkg::REQ_ACT);
      link.addr  <= issue ? next_addr : '0;
      link.bg    <= issue ? i_req_bank[3:2] : 2'h0;
      link.ba    <= issue ? i_req_bank[1:0] : 2'h0;
      if (issue && is_ref)
        link.bg <= {1'b0, i_req_rate[0]};
      if (issue && i_req_kind == dram_pkg::REQ_MODE)
        link.bg <= dram_pkg::MODE_REG_THREE_SEL[3:2];
      if (issue && i_req_kind == dram_pkg::REQ_MODE)
        link.ba <= dram_pkg::MODE_REG_THREE_SEL[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bank timer starts; auto precharge counts lockout plus precharge
  always_comb
  begin
    bank_load  = '0;
    bank_value = TW'(dram_pkg::RP_CYC);
    if (issue && i_req_kind == dram_pkg::REQ_PREA)
      bank_load = '1;
    if (issue && i_req_kind == dram_pkg::REQ_PRE)
      bank_load[i_req_bank] = 1'b1;
    if (issue && i_req_ap && (i_req_kind == dram_pkg::REQ_RD ||
        i_req_kind == dram_pkg::REQ_WR))
    begin
      bank_load[i_req_bank] = 1'b1;
      bank_value = TW'(dram_pkg::RP_CYC + dram_pkg::AP_SLACK +
                   ((i_req_kind == dram_pkg::REQ_RD) ?
                   dram_pkg::RD_AP_CYC : dram_pkg::WR_AP_CYC));
    end
  end

  // Open or idle per bank
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_bank_open <= '0;
    else if (i_clk_en && issue)
    begin
      unique case (i_req_kind)
        dram_pkg::REQ_ACT:  o_bank_open[i_req_bank] <= 1'b1;
        dram_pkg::REQ_PRE:  o_bank_open[i_req_bank] <= 1'b0;
        dram_pkg::REQ_PREA: o_bank_open <= '0;
        dram_pkg::REQ_RD, dram_pkg::REQ_WR:
          if (i_req_ap)
            o_bank_open[i_req_bank] <= 1'b0;
        default: o_bank_open <= o_bank_open;
      endcase
    end
  end

  // Activate spacing ages saturate so an idle link never blocks
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      act_age <= AGE_MAX;
      last_bg <= 2'h0;
      win_ptr <= 2'h0;
      for (int i = 0; i < 4; i++)
        win_age[i] <= AGE_MAX;
    end
    else if (i_clk_en)
    begin
      for (int i = 0; i < 4; i++)
        if (win_age[i] != AGE_MAX)
          win_age[i] <= win_age[i] + TW'(1);
      if (act_age != AGE_MAX)
        act_age <= act_age + TW'(1);
      if (issue && i_req_kind == dram_pkg::REQ_ACT)
      begin
        act_age          <= '0;
        last_bg          <= i_req_bank[3:2];
        win_age[win_ptr] <= '0;
        win_ptr          <= win_ptr + 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Refresh debt: a quarter interval owes one unit
  assign tick = (tick_cnt == 10'(REFI4_CYC - 1));

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      tick_cnt <= '0;
    else if (i_clk_en)
      tick_cnt <= tick ? '0 : tick_cnt + 10'h001;
  end

  always_comb
  begin
    next_debt = o_ref_debt + $signed({7'h00, tick});
    if (issue && is_ref)
      next_debt = next_debt - $signed({4'h0, units});
    if (next_debt > dram_pkg::DEBT_LIM)
      next_debt = dram_pkg::DEBT_LIM;
  end

  // Urgent at the postponement limit, so the gap stays bounded
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_ref_debt   <= '0;
      o_ref_urgent <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_ref_debt   <= next_debt;
      o_ref_urgent <= next_debt >= dram_pkg::DEBT_LIM;
    end
  end

  // Answers and the mode register copy
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_req_done   <= 1'b0;
      o_req_reject <= 1'b0;
      o_rate_mode  <= dram_pkg::RESET_RATE_MODE;
    end
    else if (i_clk_en)
    begin
      o_req_done   <= issue;
      o_req_reject <= take && bad;
      if (issue && i_req_kind == dram_pkg::REQ_MODE)
        o_rate_mode <= i_req_rate;
    end
  end
endmodule // dram_ctrl_end

// [core/dram_pkg.sv]
// Shared constants, types and decoders for the row and refresh link.
// Assumes both ends run on one 200 MHz clock and share this package.
package dram_pkg;
  //////////////////////////////////////////////////////////////////////
  // Times in picoseconds, then whole cycles of the system clock
  localparam int CLK_PS                  = 5000;
  localparam int ROW_PRECHARGE_PS        = 13750;
  localparam int ACT_SHORT_DELAY_PS      = 5000;
  localparam int ACT_LONG_DELAY_PS       = 6400;
  localparam int FOUR_ACT_WINDOW_PS      = 30000;
  localparam int RESTORE_PS              = 32000;
  localparam int WRITE_RECOVERY_PS       = 15000;
  localparam int REFRESH_CYCLE1_PS       = 350000;
  localparam int REFRESH_CYCLE2_PS       = 260000;
  localparam int REFRESH_CYCLE4_PS       = 160000;
  localparam int REFRESH_INTERVAL_PS     = 7800000;
  localparam int WRITE_LATENCY_CYC       = 4;
  localparam int BURST_CYC               = 4;
  // Least times round up
  localparam int RP_CYC   = (ROW_PRECHARGE_PS + CLK_PS - 1) / CLK_PS;
  localparam int RRDS_CYC = (ACT_SHORT_DELAY_PS + CLK_PS - 1) / CLK_PS;
  localparam int RRDL_CYC = (ACT_LONG_DELAY_PS + CLK_PS - 1) / CLK_PS;
  localparam int WIN_CYC  = (FOUR_ACT_WINDOW_PS + CLK_PS - 1) / CLK_PS;
  localparam int RST_CYC  = (RESTORE_PS + CLK_PS - 1) / CLK_PS;
  localparam int WREC_CYC = (WRITE_RECOVERY_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC1_CYC = (REFRESH_CYCLE1_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC2_CYC = (REFRESH_CYCLE2_PS + CLK_PS - 1) / CLK_PS;
  localparam int RFC4_CYC = (REFRESH_CYCLE4_PS + CLK_PS - 1) / CLK_PS;
  localparam int RD_AP_CYC = RST_CYC;
  localparam int WR_AP_CYC = WRITE_LATENCY_CYC + BURST_CYC + WREC_CYC;
  localparam int AP_SLACK  = 2;
  // Average interval is a longest time: quarter interval rounds down
  localparam int REFI4_CYC = REFRESH_INTERVAL_PS / (4 * CLK_PS);
  localparam int TIMER_W   = 8;
  //////////////////////////////////////////////////////////////////////
  // Geometry and command pin layout
  localparam int NB      = 16;
  localparam int ADDR_W  = 18;
  localparam int RAS_BIT = 16;
  localparam int CAS_BIT = 15;
  localparam int WE_BIT  = 14;
  localparam int AP_BIT  = 10;
  localparam int RATE_LSB = 6;
  localparam logic [3:0] MODE_REG_THREE_SEL = 4'h3;
  localparam logic [2:0] MODE_1X   = 3'h0;
  localparam logic [2:0] MODE_2X   = 3'h1;
  localparam logic [2:0] MODE_4X   = 3'h2;
  localparam logic [2:0] MODE_OTF2 = 3'h5;
  localparam logic [2:0] MODE_OTF4 = 3'h6;
  localparam logic [2:0] RESET_RATE_MODE = MODE_1X;
  // Refresh debt in quarter-interval units, same limit in every mode
  localparam logic signed [7:0] DEBT_LIM = 8'sh20;
  typedef enum logic [2:0] {CMD_DES, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
                            CMD_REF, CMD_MRS, CMD_OTHER} cmd_t;
  typedef enum logic [2:0] {REQ_ACT, REQ_RD, REQ_WR, REQ_PRE, REQ_PREA,
                            REQ_REF, REQ_MODE} req_t;
  typedef enum logic [1:0] {RATE_1X, RATE_2X, RATE_4X} rate_t;
  //////////////////////////////////////////////////////////////////////
  // Per-refresh rate: fixed modes, or bank-group bit zero on the fly
  function automatic rate_t ref_rate(input logic [2:0] mode,
                                     input logic       bg0);
    rate_t r;
    r = RATE_1X;
    if (mode == MODE_2X || (mode == MODE_OTF2 && bg0)) r = RATE_2X;
    if (mode == MODE_4X || (mode == MODE_OTF4 && bg0)) r = RATE_4X;
    return r;
  endfunction
  function automatic logic mode_legal(input logic [2:0] mode);
    return mode == MODE_1X || mode == MODE_2X || mode == MODE_4X ||
           mode == MODE_OTF2 || mode == MODE_OTF4;
  endfunction
  function automatic logic [TIMER_W-1:0] refresh_cycles(input rate_t r);
    logic [TIMER_W-1:0] c;
    c = TIMER_W'(RFC1_CYC);
    if (r == RATE_2X) c = TIMER_W'(RFC2_CYC);
    if (r == RATE_4X) c = TIMER_W'(RFC4_CYC);
    return c;
  endfunction
  function automatic logic [3:0] refresh_units(input rate_t r);
    return 4'h4 >> r;
  endfunction
endpackage

// [core/dram_cmd_if.sv]
// Command and address link between memory controller and DRAM end.
// Assumes both ends sample on the same system clock edge.
`timescale 1ns/1ps
interface dram_cmd_if;
  // Bits 16..14 of addr double as row, column and write strobes
  logic        cs_n;
  logic        act_n;
  logic [1:0]  bg;
  logic [1:0]  ba;
  logic [17:0] addr;
  modport ctrl (output cs_n, act_n, bg, ba, addr);
  modport dram (input cs_n, act_n, bg, ba, addr);
endinterface

// [core/dram_down_counter.sv]
// Loadable down counter that stops at zero.
// Assumes the owner holds i_load for one cycle per start.
`timescale 1ns/1ps
module dram_down_counter #(
  parameter int W = 8
)(
  input  logic         i_sys_clk,
  input  logic         i_reset,
  input  logic         i_clk_en,
  input  logic         i_load,
  input  logic [W-1:0] i_value,
  output logic         o_zero
);
  logic [W-1:0] count;
  // A reload restarts the period from the latest start
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      count <= '0;
    else if (i_clk_en)
    begin
      if (i_load)
        count <= i_value;
      else if (count != '0)
        count <= count - W'(1);
    end
  end
  assign o_zero = (count == '0);
endmodule // dram_down_counter

// [core/dram_device_end.sv]
// Device end: bank state, precharge, auto precharge and refresh.
// Assumes commands arrive from logic on the same clock.
`timescale 1ns/1ps
module dram_device_end (
  input  logic          i_sys_clk,
  input  logic          i_reset,
  input  logic          i_clk_en,
  dram_cmd_if.dram      link,
  input  logic [3:0]    i_probe_bank,
  output logic [17:0]   o_probe_row,
  output logic [15:0]   o_bank_open,
  output logic [15:0]   o_bank_ready,
  output logic          o_refresh_busy,
  output logic [17:0]   o_refresh_row,
  output logic [2:0]    o_rate_mode,
  output logic          o_protocol_error
);
  localparam int TW = dram_pkg::TIMER_W;

  dram_pkg::cmd_t  cmd;
  logic [3:0]      sel;
  logic [15:0]     ready_now;
  logic [15:0]     rp_zero;
  logic [15:0]     ap_zero;
  logic [15:0]     ap_pend;
  logic [15:0]     ap_load;
  logic [15:0]     ap_fire;
  logic [15:0]     pre_hit;
  logic            rfc_zero;
  logic [17:0]     row_q [16];
  logic            bad;

  //////////////////////////////////////////////////////////////////////
  // Strobe decode: row, column and write strobes ride on address bits
  always_comb
  begin
    cmd = dram_pkg::CMD_OTHER;
    unique case ({link.addr[dram_pkg::RAS_BIT],
                  link.addr[dram_pkg::CAS_BIT],
                  link.addr[dram_pkg::WE_BIT]})
      3'h0: cmd = dram_pkg::CMD_MRS;
      3'h1: cmd = dram_pkg::CMD_REF;
      3'h2: cmd = dram_pkg::CMD_PRE;
      3'h4: cmd = dram_pkg::CMD_WR;
      3'h5: cmd = dram_pkg::CMD_RD;
      default: cmd = dram_pkg::CMD_OTHER;
    endcase
    if (!link.act_n)
      cmd = dram_pkg::CMD_ACT;
    if (link.cs_n)
      cmd = dram_pkg::CMD_DES;
  end
  assign sel = {link.bg, link.ba};

  //////////////////////////////////////////////////////////////////////
  // Banks are independent, so one bank's lockout never stalls another
  for (genvar b = 0; b < dram_pkg::NB; b++)
  begin : g_bank
    assign pre_hit[b] = (cmd == dram_pkg::CMD_PRE) &&
                        (sel == 4'(b) || link.addr[dram_pkg::AP_BIT]);
    assign ap_load[b] = (cmd == dram_pkg::CMD_RD ||
                         cmd == dram_pkg::CMD_WR) && sel == 4'(b) &&
                        link.addr[dram_pkg::AP_BIT];
    assign ap_fire[b] = ap_pend[b] && ap_zero[b] && !pre_hit[b];
    assign ready_now[b] = !o_bank_open[b] && rp_zero[b] && !ap_pend[b];

    // Lockout covers restore for a read; latency, burst and recovery for a write
    dram_down_counter #(.W(TW)) u_lockout (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_load    (ap_load[b]),
      .i_value   ((cmd == dram_pkg::CMD_RD) ? TW'(dram_pkg::RD_AP_CYC) :
                  TW'(dram_pkg::WR_AP_CYC)),
      .o_zero    (ap_zero[b])
    );

    // Any precharge, even to an idle bank, restarts the period
    dram_down_counter #(.W(TW)) u_precharge (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_load    (pre_hit[b] || ap_fire[b]),
      .i_value   (TW'(dram_pkg::RP_CYC)),
      .o_zero    (rp_zero[b])
    );

    always_ff @(posedge i_sys_clk)
    begin
      if (i_reset)
      begin
        o_bank_open[b]  <= 1'b0;
        o_bank_ready[b] <= 1'b0;
        ap_pend[b]      <= 1'b0;
        row_q[b]        <= '0;
      end
      else if (i_clk_en)
      begin
        o_bank_ready[b] <= ready_now[b] && rfc_zero;
        if (ap_load[b])
          ap_pend[b] <= 1'b1;
        else if (ap_fire[b] || pre_hit[b])
          ap_pend[b] <= 1'b0;
        if (cmd == dram_pkg::CMD_ACT && sel == 4'(b))
        begin
          o_bank_open[b] <= 1'b1;
          row_q[b]       <= link.addr;
        end
        else if (pre_hit[b] || ap_fire[b] || cmd == dram_pkg::CMD_REF)
          o_bank_open[b] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Refresh: row from internal counter, external address ignored
  dram_down_counter #(.W(TW)) u_refresh (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_clk_en  (i_clk_en),
    .i_load    (cmd == dram_pkg::CMD_REF),
    .i_value   (dram_pkg::refresh_cycles(
                dram_pkg::ref_rate(o_rate_mode, link.bg[0]))),
    .o_zero    (rfc_zero)
  );

  // Misuse seen on the link; sticky, nothing clears it but reset
  always_comb
  begin
    bad = !rfc_zero && cmd != dram_pkg::CMD_DES;
    if (cmd == dram_pkg::CMD_ACT && !ready_now[sel])
      bad = 1'b1;
    if ((cmd == dram_pkg::CMD_RD || cmd == dram_pkg::CMD_WR) &&
        (!o_bank_open[sel] || ap_pend[sel]))
      bad = 1'b1;
    if (cmd == dram_pkg::CMD_REF && !(&ready_now))
      bad = 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_refresh_busy   <= 1'b0;
      o_refresh_row    <= '0;
      o_rate_mode      <= dram_pkg::RESET_RATE_MODE;
      o_protocol_error <= 1'b0;
      o_probe_row      <= '0;
    end
    else if (i_clk_en)
    begin
      o_refresh_busy <= (cmd == dram_pkg::CMD_REF) || !rfc_zero;
      if (cmd == dram_pkg::CMD_REF)
        o_refresh_row <= o_refresh_row + 18'h00001;
      if (cmd == dram_pkg::CMD_MRS && sel == dram_pkg::MODE_REG_THREE_SEL)
        o_rate_mode <= link.addr[dram_pkg::RATE_LSB +: 3];
      if (bad)
        o_protocol_error <= 1'b1;
      o_probe_row <= row_q[i_probe_bank];
    end
  end
endmodule // dram_device_end

// [dv/dram_link_sva.sv]
// Checker on the command link between the two ends.
// Assumes it sits beside the interface, fed by its signals.
`timescale 1ns/1ps
module dram_link_sva (
  input logic        i_sys_clk,
  input logic        i_reset,
  input logic        cs_n,
  input logic        act_n,
  input logic [1:0]  bg,
  input logic [1:0]  ba,
  input logic [17:0] addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [3:0]  bk;
  logic        act, rf, pr, rw;
  logic [15:0] opened;
  logic [4:0]  hist;
  //////////////////////////////////////////////////////////////////////
  // Decode from the strobe bits
  assign bk  = {bg, ba};
  assign act = !cs_n && !act_n;
  assign rf  = !cs_n && act_n && addr[16:14] == 3'h1;
  assign pr  = !cs_n && act_n && addr[16:14] == 3'h2;
  assign rw  = !cs_n && act_n && addr[16:15] == 2'h2;
  // Bank state seen on the wire; auto precharge closes at once, safe side
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset) opened <= 16'h0000;
    else if (act) opened <= opened | (16'h0001 << bk);
    else if (pr && addr[10]) opened <= 16'h0000;
    else if (pr || (rw && addr[10])) opened <= opened & ~(16'h0001 << bk);
  end
  // Activates in the last five cycles
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset) hist <= 5'h00;
    else hist <= {hist[3:0], act};
  end
  //////////////////////////////////////////////////////////////////////
  chk_cmd_single: assert property (!cs_n |=> cs_n)
    else $error("command held longer than one cycle");
  chk_four_act: assert property (act |-> $countones(hist) <= 3)
    else $error("too many activates in window");
  chk_act_closed: assert property (act |-> !opened[bk])
    else $error("activate to open bank");
  chk_rdwr_open: assert property (rw |-> opened[bk])
    else $error("access to idle bank");
  chk_ref_idle: assert property (rf |-> opened == 16'h0000
    && !$past(pr) && !$past(pr, 2)) else $error("refresh too early");
  chk_ref_quiet: assert property (rf |=> cs_n[*8])
    else $error("command during refresh");
  chk_ref_addr: assert property (rf |-> addr[17] == 1'b0
    && addr[13:0] == 14'h0000) else $error("refresh address not clear");
  chk_reset_idle: assert property ($fell(i_reset) |-> cs_n && act_n)
    else $error("link busy after reset");
endmodule // dram_link_sva

// [dv/test_dram_row_and_refresh_commands.sv]
// Bench joining controller end and device end over the link.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
module test_dram_row_and_refresh_commands;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              valid = 1'b0;
  dram_pkg::req_t    kind = dram_pkg::REQ_ACT;
  logic [3:0]        bank = 4'h0;
  logic [17:0]       row = 18'h00000;
  logic              ap = 1'b0;
  logic [2:0]        rate = 3'h0;
  logic [3:0]        probe = 4'h0;
  logic              done, rej, urgent, busy, perr;
  logic signed [7:0] debt;
  logic [15:0]       d_open, d_ready, c_open;
  logic [17:0]       p_row, r_row, rr;
  logic [2:0]        d_rate, c_rate;
  logic [2:0]        md [5];
  int                errors = 0;
  int                tests_run = 0;
  int                cycles = 0;
  dram_cmd_if link ();
  dram_ctrl_end #(.REFI4_CYC(20)) dram_ctrl_end_inst (
    .i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .link(link),
    .i_req_valid(valid), .i_req_kind(kind), .i_req_bank(bank),
    .i_req_row(row), .i_req_ap(ap), .i_req_rate(rate),
    .o_req_done(done), .o_req_reject(rej), .o_ref_urgent(urgent),
    .o_ref_debt(debt), .o_bank_open(c_open), .o_rate_mode(c_rate));
  dram_device_end dram_device_end_inst (
    .i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .link(link),
    .i_probe_bank(probe), .o_probe_row(p_row), .o_bank_open(d_open),
    .o_bank_ready(d_ready), .o_refresh_busy(busy), .o_refresh_row(r_row),
    .o_rate_mode(d_rate), .o_protocol_error(perr));
  dram_link_sva dram_link_sva_inst (
    .i_sys_clk(clk), .i_reset(rst), .cs_n(link.cs_n), .act_n(link.act_n),
    .bg(link.bg), .ba(link.ba), .addr(link.addr));
  //////////////////////////////////////////////////////////////////////
  // Clock, and a hang guard well above the expected run
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Request held until answered; waits are bounded, not fixed
  task automatic req(input dram_pkg::req_t k, input logic [3:0] b,
                     input logic [17:0] r, input logic a,
                     input logic [2:0] m, input logic rj);
    @(negedge clk);
    valid = 1'b1;
    kind = k;
    bank = b;
    row = r;
    ap = a;
    rate = m;
    for (int n = 0; n < 400 && (done | rej) !== 1'b1; n++) cyc(1);
    chk("answer", 18'({rj, !rj}), 18'({rej, done}));
    @(negedge clk);
    valid = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_rows();
    req(dram_pkg::REQ_ACT, 4'h5, 18'h2ABCD, 1'b0, 3'h0, 1'b0);
    probe = 4'h5;
    cyc(3);
    chk("probe_row", 18'h2ABCD, p_row);
    chk("open", 18'h00020, 18'(d_open));
    req(dram_pkg::REQ_ACT, 4'h5, 18'h00001, 1'b0, 3'h0, 1'b1);
    req(dram_pkg::REQ_RD, 4'h2, 18'h00000, 1'b0, 3'h0, 1'b1);
    req(dram_pkg::REQ_PRE, 4'h0, 18'h00000, 1'b0, 3'h0, 1'b0);
    $display("end t_rows");
  endtask
  // Back-to-back activates across groups, then close all
  task automatic t_spacing();
    for (int i = 0; i < 5; i++)
      req(dram_pkg::REQ_ACT, i == 4 ? 4'h1 : 4'(i * 4), 18'(i), 1'b0,
          3'h0, 1'b0);
    cyc(2);
    chk("open_all", 18'h01133, 18'(d_open));
    chk("c_open", 18'h01133, 18'(c_open));
    req(dram_pkg::REQ_PREA, 4'h0, 18'h00000, 1'b0, 3'h0, 1'b0);
    cyc(2);
    chk("closed", 18'h00000, 18'(d_open));
    cyc(6);
    chk("ready", 18'h0FFFF, 18'(d_ready));
    $display("end t_spacing");
  endtask
  task automatic t_auto_pre();
    req(dram_pkg::REQ_ACT, 4'h3, 18'h00033, 1'b0, 3'h0, 1'b0);
    req(dram_pkg::REQ_ACT, 4'h7, 18'h00077, 1'b0, 3'h0, 1'b0);
    req(dram_pkg::REQ_RD, 4'h3, 18'h00000, 1'b1, 3'h0, 1'b0);
    cyc(2);
    chk("rd_lock", 18'h1, 18'(d_open[3]));
    req(dram_pkg::REQ_RD, 4'h7, 18'h00000, 1'b0, 3'h0, 1'b0);
    cyc(12);
    chk("rd_closed", 18'h0, 18'(d_open[3]));
    req(dram_pkg::REQ_WR, 4'h7, 18'h00000, 1'b1, 3'h0, 1'b0);
    cyc(8);
    chk("wr_lock", 18'h1, 18'(d_open[7]));
    cyc(8);
    chk("wr_closed", 18'h0, 18'(d_open[7]));
    $display("end t_auto_pre");
  endtask
  // Every legal rate mode, a refresh in each, reserved codes 3 and 7 refused
  task automatic t_refresh();
    md = '{dram_pkg::MODE_1X, dram_pkg::MODE_2X, dram_pkg::MODE_4X,
           dram_pkg::MODE_OTF2, dram_pkg::MODE_OTF4};
    foreach (md[i])
    begin
      req(dram_pkg::REQ_MODE, 4'h3, 18'h00000, 1'b0, md[i], 1'b0);
      cyc(2);
      chk("rate", 18'(md[i]), 18'(d_rate));
      chk("c_rate", 18'(md[i]), 18'(c_rate));
      rr = r_row;
      req(dram_pkg::REQ_REF, 4'h0, 18'h3FFFF, 1'b0, 3'h1, 1'b0);
      cyc(2);
      chk("busy", 18'h1, 18'(busy));
      chk("ref_row", rr + 18'h1, r_row);
    end
    req(dram_pkg::REQ_MODE, 4'h3, 18'h00000, 1'b0, 3'h3, 1'b1);
    req(dram_pkg::REQ_MODE, 4'h3, 18'h00000, 1'b0, 3'h7, 1'b1);
    $display("end t_refresh");
  endtask
  task automatic t_debt();
    req(dram_pkg::REQ_MODE, 4'h3, 18'h00000, 1'b0, 3'h0, 1'b0);
    for (int n = 0; n < 1500 && urgent !== 1'b1; n++) cyc(1);
    chk("debt_max", 18'h20, 18'(debt));
    req(dram_pkg::REQ_REF, 4'h0, 18'h00000, 1'b0, 3'h0, 1'b0);
    cyc(1);
    chk("debt_paid", 18'h1, 18'(debt == 8'sh1C || debt == 8'sh1D));
    chk("urgent", 18'h0, 18'(urgent));
    chk("proto_err", 18'h0, 18'(perr));
    $display("end t_debt");
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_rows();
    t_spacing();
    t_auto_pre();
    t_refresh();
    t_debt();
    tally_and_finish();
  end
endmodule // test_dram_row_and_refresh_commands
